// [pwm_unit.sv]
// timer unit with master interval channel and one-count pwm slaves
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module pwm_unit
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            nrst_in,
  // wishbone slave
  input  wire logic            wb_cyc_in,
  input  wire logic            wb_stb_in,
  input  wire logic            wb_we_in,
  input  wire logic [7:0]      wb_adr_in,
  input  wire logic [3:0]      wb_sel_in,
  input  wire logic [31:0]     wb_dat_in,
  output logic      [31:0]     wb_dat_out,
  output logic                 wb_ack_out,
  // wave pins
  output logic      [NCH-1:0]  slave_wave_pin_out,
  output logic      [NCH-1:0]  slave_wave_pin_oe_out,
  // interrupt events
  output logic      [NCH-1:0]  period_interrupt_out
);
  // ==========================================================
  // registers
  logic                 unit_clock_gate_q;
  logic [15:0]          prescaler_select_q;
  logic [NCH-1:0]       channel_running_flag_q;
  logic [NCH-1:0]       output_value_bits_q;
  logic [NCH-1:0]       output_enable_bits_q;
  logic [NCH-1:0]       output_polarity_bits_q;
  logic [NCH-1:0]       output_role_bits_q;
  logic [NCH-1:0]       port_latch_q;
  logic [NCH-1:0]       port_mode_q;
  logic [NCH-1:0]       irq_flag_q;
  logic [15:0]          mode_q     [NCH];
  logic [15:0]          reload_q   [NCH];
  logic [15:0]          counter_q  [NCH];
  logic [NCH-1:0]       trig_pend_q;
  logic [NCH-1:0]       tick_ch;
  logic [NCH-1:0]       zero_ev;
  logic [NCH-1:0]       wave_next;
  logic [NCH-1:0]       start_req;
  logic [NCH-1:0]       stop_req;
  logic                 tick_a;
  logic                 tick_b;
  logic                 wr;
  logic                 rd_go;
  logic [31:0]          rd_data;
  logic [15:0]          wmask;

  // ==========================================================
  // bus decode
  // one wait state: ack one cycle after the request is seen
  assign rd_go = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr    = rd_go && wb_we_in && unit_clock_gate_q;
  assign wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign start_req = (wr && wb_adr_in == ADR_START) ?
                     wb_dat_in[NCH-1:0] : '0;
  assign stop_req  = (wr && wb_adr_in == ADR_STOP) ?
                     wb_dat_in[NCH-1:0] : '0;

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_in)
      ADR_GATE:     rd_data[0]     = unit_clock_gate_q;
      ADR_PRESC:    rd_data[15:0]  = prescaler_select_q;
      ADR_RUN:      rd_data[7:0]   = channel_running_flag_q;
      ADR_OUTVAL:   rd_data[7:0]   = output_value_bits_q;
      ADR_OUTEN:    rd_data[7:0]   = output_enable_bits_q;
      ADR_POL:      rd_data[7:0]   = output_polarity_bits_q;
      ADR_ROLE:     rd_data[7:0]   = output_role_bits_q;
      ADR_PORT:     rd_data[7:0]   = port_latch_q;
      ADR_PORTMODE: rd_data[7:0]   = port_mode_q;
      ADR_IRQ:      rd_data[7:0]   = irq_flag_q;
      default: begin
        if (wb_adr_in[7:5] == ADR_MODE0[7:5])
          rd_data[15:0] = mode_q[wb_adr_in[4:2]];
        else if (wb_adr_in[7:5] == ADR_RELOAD0[7:5])
          rd_data[15:0] = reload_q[wb_adr_in[4:2]];
        else if (wb_adr_in[7:5] == ADR_COUNT0[7:5])
          rd_data[15:0] = counter_q[wb_adr_in[4:2]];
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= rd_go;
      wb_dat_out <= rd_go ? rd_data : 32'h0000_0000;
    end
  end

  // ==========================================================
  // unit gate: always writable so the unit can be switched on
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in)
      unit_clock_gate_q <= 1'b0;
    else if (rd_go && wb_we_in && wb_adr_in == ADR_GATE && wb_sel_in[0])
      unit_clock_gate_q <= wb_dat_in[0];
  end

  // ==========================================================
  // plain control registers; all back to reset values while the unit is gated (port mode to all ones)
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prescaler_select_q     <= 16'h0000;
      output_enable_bits_q   <= '0;
      output_polarity_bits_q <= '0;
      output_role_bits_q     <= '0;
      port_latch_q           <= '0;
      port_mode_q            <= PORTMODE_RST;
    end else if (!unit_clock_gate_q) begin
      prescaler_select_q     <= 16'h0000;
      output_enable_bits_q   <= '0;
      output_polarity_bits_q <= '0;
      output_role_bits_q     <= '0;
      port_latch_q           <= '0;
      port_mode_q            <= PORTMODE_RST;
    end else if (wr && wb_sel_in[0]) begin
      unique case (wb_adr_in)
        ADR_PRESC:    prescaler_select_q[7:0] <= wb_dat_in[7:0];
        ADR_OUTEN:    output_enable_bits_q    <= wb_dat_in[7:0];
        ADR_POL:      output_polarity_bits_q  <= wb_dat_in[7:0];
        ADR_ROLE:     output_role_bits_q      <= wb_dat_in[7:0];
        ADR_PORT:     port_latch_q            <= wb_dat_in[7:0];
        ADR_PORTMODE: port_mode_q             <= wb_dat_in[7:0];
        default:      ;
      endcase
    end
  end

  // ==========================================================
  // count clock sources
  pwm_prescaler u_presc (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .run_in     (unit_clock_gate_q),
    .sel_a_in   (prescaler_select_q[PRESC_W-1:0]),
    .sel_b_in   (prescaler_select_q[PRESC_W+3:4]),
    .tick_a_out (tick_a),
    .tick_b_out (tick_b)
  );

  // ==========================================================
  // per channel counters
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      logic leader_trig;
      // channel 0 is the leader; channels above 2 take channel 2 when its leader bit is set
      if (g == 0) begin : gen_l0
        assign leader_trig = 1'b0;
      end else begin : gen_ln
        assign leader_trig = (g > 2 && mode_q[2][MODE_LEADER_BIT]) ?
                             period_interrupt_out[2] :
                             period_interrupt_out[0];
      end
      assign tick_ch[g] = mode_q[g][MODE_CKSEL_BIT] ? tick_b : tick_a;
      // one event per period: on the step to zero, or on a zero load
      assign zero_ev[g] = tick_ch[g] && channel_running_flag_q[g] &&
                          (trig_pend_q[g] ? reload_q[g] == COUNT_ZERO :
                           counter_q[g] == 16'h0001);

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
          mode_q[g] <= MODE_RST;
        else if (!unit_clock_gate_q)
          mode_q[g] <= MODE_RST;
        else if (wr && wb_adr_in == ADR_MODE0 + 8'(4 * g))
          mode_q[g] <= (mode_q[g] & ~wmask) | (wb_dat_in[15:0] & wmask &
                       ~((LEADER_CAPABLE[g] || SPLIT_CAPABLE[g]) ? 16'h0000 :
                       16'h0800));
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
          reload_q[g] <= RELOAD_RST;
        else if (!unit_clock_gate_q)
          reload_q[g] <= RELOAD_RST;
        else if (wr && wb_adr_in == ADR_RELOAD0 + 8'(4 * g))
          reload_q[g] <= (reload_q[g] & ~wmask) | (wb_dat_in[15:0] & wmask);
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
          channel_running_flag_q[g] <= 1'b0;
        else if (!unit_clock_gate_q || stop_req[g])
          channel_running_flag_q[g] <= 1'b0;
        else if (start_req[g])
          channel_running_flag_q[g] <= 1'b1;
      end

      // leader: interval mode; follower: one-count mode
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          counter_q[g]             <= RELOAD_RST;
          trig_pend_q[g]           <= 1'b0;
          period_interrupt_out[g]  <= 1'b0;
        end else if (!channel_running_flag_q[g]) begin
          counter_q[g]             <= reload_q[g];
          trig_pend_q[g]           <= 1'b0;
          period_interrupt_out[g]  <= 1'b0;
        end else begin
          period_interrupt_out[g]  <= 1'b0;
          if (!output_role_bits_q[g]) begin
            if (tick_ch[g]) begin
              if (counter_q[g] == COUNT_ZERO) begin
                counter_q[g]            <= reload_q[g];
                period_interrupt_out[g] <= 1'b1;
              end else
                counter_q[g] <= counter_q[g] - 16'h0001;
            end
          end else begin
            // trigger taken on the next count clock, one after the event
            if (tick_ch[g] && trig_pend_q[g]) begin
              counter_q[g]   <= reload_q[g];
              trig_pend_q[g] <= 1'b0;
            end else if (tick_ch[g] && counter_q[g] != COUNT_ZERO)
              counter_q[g] <= counter_q[g] - 16'h0001;
            if (leader_trig)
              trig_pend_q[g] <= 1'b1; // a fresh trigger is never lost
            if (zero_ev[g])
              period_interrupt_out[g] <= 1'b1;
          end
        end
      end

      // wave level: active on the first count clock after the trigger
      always_comb begin
        wave_next[g] = output_value_bits_q[g];
        if (output_enable_bits_q[g] && channel_running_flag_q[g] &&
            output_role_bits_q[g] && tick_ch[g]) begin
          if (trig_pend_q[g] && reload_q[g] != COUNT_ZERO)
            wave_next[g] = ~output_polarity_bits_q[g];
          else if (counter_q[g] == 16'h0001 || reload_q[g] == COUNT_ZERO)
            wave_next[g] = output_polarity_bits_q[g];
        end
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
          output_value_bits_q[g] <= 1'b0;
        else if (!unit_clock_gate_q)
          output_value_bits_q[g] <= 1'b0;
        else if (wr && wb_adr_in == ADR_OUTVAL && wb_sel_in[0])
          output_value_bits_q[g] <= wb_dat_in[g];
        else if (output_role_bits_q[g])
          output_value_bits_q[g] <= wave_next[g];
        // leader value bit never moves by counting
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
          irq_flag_q[g] <= 1'b0;
        else if (period_interrupt_out[g])
          irq_flag_q[g] <= 1'b1; // set wins over the clear
        else if (wr && wb_adr_in == ADR_IRQ && wb_dat_in[g])
          irq_flag_q[g] <= 1'b0;
      end

      // pin: hi-z until port mode is output, then drives value bit OR port latch
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          slave_wave_pin_out[g]    <= 1'b0;
          slave_wave_pin_oe_out[g] <= 1'b0;
        end else begin
          slave_wave_pin_oe_out[g] <= !port_mode_q[g];
          slave_wave_pin_out[g]    <= output_value_bits_q[g] |
                                      port_latch_q[g];
        end
      end
    end
  endgenerate
endmodule : pwm_unit

// [pwm_pkg.sv]
// constants and register map for the multi-channel pwm output block
package pwm_pkg;
  localparam int unsigned NCH = 8;
  // byte addresses (word index = address / 4)
  localparam logic [7:0] ADR_GATE     = 8'h00;
  localparam logic [7:0] ADR_PRESC    = 8'h04;
  localparam logic [7:0] ADR_START    = 8'h08;
  localparam logic [7:0] ADR_STOP     = 8'h0C;
  localparam logic [7:0] ADR_RUN      = 8'h10;
  localparam logic [7:0] ADR_OUTVAL   = 8'h14;
  localparam logic [7:0] ADR_OUTEN    = 8'h18;
  localparam logic [7:0] ADR_POL      = 8'h1C;
  localparam logic [7:0] ADR_ROLE     = 8'h20;
  localparam logic [7:0] ADR_PORT     = 8'h24;
  localparam logic [7:0] ADR_PORTMODE = 8'h28;
  localparam logic [7:0] ADR_IRQ      = 8'h2C;
  localparam logic [7:0] ADR_MODE0    = 8'h40;
  localparam logic [7:0] ADR_RELOAD0  = 8'h60;
  localparam logic [7:0] ADR_COUNT0   = 8'h80;
  // mode register fields
  localparam int unsigned MODE_CKSEL_BIT  = 15;
  localparam int unsigned MODE_LEADER_BIT = 11;
  localparam logic [15:0] MODE_RST        = 16'h0000;
  localparam logic [15:0] RELOAD_RST      = 16'hFFFF;
  localparam logic [7:0]  PORTMODE_RST    = 8'hFF;
  localparam logic [7:0]  LEADER_CAPABLE  = 8'h54;
  localparam logic [7:0]  SPLIT_CAPABLE   = 8'h0A;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;
  localparam int unsigned PRESC_W         = 4;
endpackage : pwm_pkg

// [pwm_prescaler.sv]
// prescaler: two count clock enables from the system clock
`timescale 1ns/100ps
module pwm_prescaler
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  // control
  input  wire logic               run_in,
  input  wire logic [PRESC_W-1:0] sel_a_in,
  input  wire logic [PRESC_W-1:0] sel_b_in,
  // enables
  output logic                    tick_a_out,
  output logic                    tick_b_out
);
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [15:0] mask_a;
  logic [15:0] mask_b;

  assign div_d  = div_q + 16'h0001;
  assign mask_a = (16'h0001 << sel_a_in) - 16'h0001;
  assign mask_b = (16'h0001 << sel_b_in) - 16'h0001;

  // no count clock at all while the unit is gated
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q      <= 16'h0000;
      tick_a_out <= 1'b0;
      tick_b_out <= 1'b0;
    end else if (!run_in) begin
      div_q      <= 16'h0000;
      tick_a_out <= 1'b0;
      tick_b_out <= 1'b0;
    end else begin
      div_q      <= div_d;
      tick_a_out <= (div_q & mask_a) == mask_a;
      tick_b_out <= (div_q & mask_b) == mask_b;
    end
  end
endmodule : pwm_prescaler

// [pwm_unit_properties.sv]
// concurrent checks on the pwm unit ports
`timescale 1ns/100ps
module pwm_unit_properties
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic           clk_in,
  input wire logic           nrst_in,
  // bus
  input wire logic           wb_cyc_in,
  input wire logic           wb_stb_in,
  input wire logic [31:0]    wb_dat_out,
  input wire logic           wb_ack_out,
  // pins and events
  input wire logic [NCH-1:0] slave_wave_pin_out,
  input wire logic [NCH-1:0] slave_wave_pin_oe_out,
  input wire logic [NCH-1:0] period_interrupt_out
);
  // ==========================================
  // helpers
  logic any_ack_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) any_ack_q <= 1'b0;
    else if (wb_ack_out) any_ack_q <= 1'b1;
  end
  sequence req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence ans_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  // ==========================================
  // properties
  a_req_ack: assert property (req_s |=> ans_s)
    else $error("bus answer not one cycle");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  a_ack_cause: assert property (
    wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  a_ack_idle: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack while idle");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data outside ack");
  a_reset_quiet: assert property ($rose(nrst_in) |->
    slave_wave_pin_out == '0 && slave_wave_pin_oe_out == '0
    && period_interrupt_out == '0)
    else $error("outputs active after reset");
  a_oe_after_write: assert property ($changed(slave_wave_pin_oe_out) |->
    $past(wb_ack_out) || $past(wb_ack_out, 2))
    else $error("pin enable moved without a write");
  a_irq_setup: assert property (|period_interrupt_out |-> any_ack_q)
    else $error("event before any setup");
endmodule : pwm_unit_properties

// [pwm_load.sv]
// external load model on the wave pins
`timescale 1ns/100ps
module pwm_load
  import pwm_pkg::*;
(
  // pins from the unit
  input  wire logic [NCH-1:0] pin_in,
  input  wire logic [NCH-1:0] oe_in,
  // level seen by the load
  output logic      [NCH-1:0] line_out
);
  // undriven lines sink to the pull-down, never keep the last level
  assign line_out = pin_in & oe_in;
endmodule : pwm_load

// [testbench.sv]
// self-checking bench for the pwm unit
`timescale 1ns/100ps
module testbench
  import pwm_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d;} row_t;
  logic           clk_in = 0;
  logic           nrst_in = 0;
  logic           cyc = 0;
  logic           stb = 0;
  logic           we = 0;
  logic [7:0]     adr = '0;
  logic [31:0]    wdat = '0;
  logic [31:0]    rd;
  logic [31:0]    rdat;
  logic           ack;
  logic [NCH-1:0] pins, oe, irq, line;
  int             fail_count = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  int             hi [NCH];
  int             nirq0, nirq1;
  row_t           rows [5] = '{'{ADR_OUTVAL, 32'h0000_00A5},
    '{ADR_OUTEN, 32'h0000_005A}, '{ADR_POL, 32'h0000_003C},
    '{ADR_ROLE, 32'h0000_00C3}, '{ADR_RELOAD0 + 8'h04, 32'h0000_1234}};
  logic [15:0]    duty [5] = '{16'h0004, 16'h0002, 16'h0009, 16'h0002,
    16'h0002};
  always #4 clk_in = ~clk_in;
  pwm_unit u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .slave_wave_pin_out(pins), .slave_wave_pin_oe_out(oe),
    .period_interrupt_out(irq));
  pwm_load u_load (.pin_in(pins), .oe_in(oe), .line_out(line));
  // ==========================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_in); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask : rdchk
  // hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      close_out();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    wb(1'b1, ADR_OUTVAL, 32'h0000_00FF);
    rdchk(ADR_OUTVAL, 32'h0000_0000);
    wb(1'b1, ADR_GATE, 32'h0000_0001);
    rdchk(ADR_GATE, 32'h0000_0001);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].d);
    end
    for (int n = 0; n < NCH; n++) begin
      wb(1'b1, ADR_MODE0 + 8'(4 * n), 32'h0000_0800);
      rdchk(ADR_MODE0 + 8'(4 * n), (LEADER_CAPABLE[n] | SPLIT_CAPABLE[n])
        ? 32'h0000_0800 : 32'h0000_0000);
      wb(1'b1, ADR_MODE0 + 8'(4 * n), 32'h0000_0000);
    end
    wb(1'b1, ADR_PRESC, 32'h0000_0000);
    foreach (duty[k]) wb(1'b1, ADR_RELOAD0 + 8'(4 * k), {16'h0000, duty[k]});
    wb(1'b1, ADR_ROLE, 32'h0000_001E);
    wb(1'b1, ADR_POL, 32'h0000_0008);
    wb(1'b1, ADR_OUTVAL, 32'h0000_0008);
    wb(1'b1, ADR_OUTEN, 32'h0000_000E);
    check(32'(oe), 32'h0000_0000);
    wb(1'b1, ADR_PORT, 32'h0000_0000);
    wb(1'b1, ADR_PORTMODE, 32'h0000_0000);
    repeat (3) @(posedge clk_in);
    check(32'(oe), 32'h0000_00FF);
    check(32'(line), 32'h0000_0008);
    wb(1'b1, ADR_START, 32'h0000_001F);
    rdchk(ADR_RUN, 32'h0000_001F);
    repeat (20) @(posedge clk_in);
    nirq0 = 0;
    nirq1 = 0;
    foreach (hi[k]) hi[k] = 0;
    repeat (50) begin
      @(posedge clk_in);
      foreach (hi[k]) hi[k] += int'(line[k]);
      nirq0 += int'(irq[0]);
      nirq1 += int'(irq[1]);
    end
    check(32'(hi[0]), 32'd0);
    check(32'(hi[1]), 32'd20);
    check(32'(hi[2]), 32'd50);
    check(32'(hi[3]), 32'd30);
    check(32'(hi[4]), 32'd0);
    check(32'(nirq0), 32'd10);
    check(32'(nirq1), 32'd10);
    rdchk(ADR_IRQ, 32'h0000_001B);
    wb(1'b1, ADR_STOP, 32'h0000_001F);
    wb(1'b1, ADR_IRQ, 32'h0000_00FF);
    rdchk(ADR_IRQ, 32'h0000_0000);
    wb(1'b1, ADR_GATE, 32'h0000_0000);
    rdchk(ADR_OUTVAL, 32'h0000_0000);
    rdchk(ADR_RUN, 32'h0000_0000);
    rdchk(8'hFC, 32'h0000_0000);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    @(posedge clk_in);
    check({8'h00, pins, oe, irq}, 32'h0000_0000);
    nrst_in <= 1'b1;
    close_out();
  end
endmodule : testbench
bind pwm_unit pwm_unit_properties u_props (.clk_in(clk_in),
  .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .slave_wave_pin_out(slave_wave_pin_out),
  .slave_wave_pin_oe_out(slave_wave_pin_oe_out),
  .period_interrupt_out(period_interrupt_out));
